/* include/lane_ovr_pkg.sv */
// Package with register map, field layout, reset values and timing constants.
package lane_ovr_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [11:0] IDX_SPARE_LANE = 12'h20B;
  localparam logic [11:0] IDX_SYNC_MODE = 12'h20F;
  localparam logic [11:0] IDX_GAIN_CFG = 12'h210;
  localparam logic [11:0] IDX_THR_I = 12'h211;
  localparam logic [11:0] IDX_THR_Q = 12'h212;
  localparam logic [11:0] IDX_OVERRANGE_OUTPUT_CONFIG = 12'h213;
  localparam int ADDR_SHIFT = 2;
  // Reset values.
  localparam logic [7:0] RST_SPARE_LANE = 8'h00;
  localparam logic [7:0] RST_SYNC_MODE = 8'h00;
  localparam logic [7:0] RST_GAIN_CFG = 8'h00;
  localparam logic [7:0] RST_THR_I = 8'hF2;
  localparam logic [7:0] RST_THR_Q = 8'hAB;
  localparam logic [7:0] RST_OVERRANGE_OUTPUT_CONFIG = 8'h07;
  // Field positions.
  localparam int SPARE_SER_BIT = 0;
  localparam int SPARE_LANE_LSB = 1;
  localparam int SPARE_LANE_MSB = 7;
  localparam int FILTER_GAIN_DOUBLE_BIT = 0;
  localparam int PIN_EN_BIT = 3;
  localparam int HOLD_EXP_MSB = 2;
  // Sync header mode encodings.
  localparam logic [1:0] SH_CRC12 = 2'h0;
  localparam logic [1:0] SH_FEC = 2'h2;
  // Test pattern codes.
  localparam logic [3:0] TP_NONE = 4'h0;
  localparam logic [3:0] TP_RAMP = 4'h4;
  localparam logic [3:0] TP_ALT = 4'h5;
  // Over-range pulse stretch base length in device clock cycles.
  localparam int OVR_BASE_CYCLES = 8;
  localparam int OVR_CNT_W = 11;
  localparam int LANES = 8;
endpackage

/* src/ovr_stretch.sv */
// Over-range pulse stretcher for one output pin.
`timescale 1ns/1ps
module ovr_stretch (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Control.
  input wire logic i_en,
  input wire logic [2:0] i_exp,
  input wire logic i_hit,
  // Pin output.
  output logic o_pin
);
  logic [lane_ovr_pkg::OVR_CNT_W-1:0] cnt_q;
  logic [lane_ovr_pkg::OVR_CNT_W-1:0] len;

  // Hold length is the base of eight shifted by the exponent.
  assign len = lane_ovr_pkg::OVR_CNT_W'(lane_ovr_pkg::OVR_BASE_CYCLES) << i_exp;

  // A new hit restarts the window so the pulse is never shorter than len unless reset or a cleared enable cuts it.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_en) begin
      cnt_q <= '0;
    end else if (i_hit) begin
      cnt_q <= len;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Pin is held low while the enable is clear.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= i_en && (i_hit || cnt_q > 1);
    end
  end
endmodule

/* src/lane_overrange_output_config.sv */
// Spare lane, sync header, gain filter_gain_double and over-range configuration block.
`timescale 1ns/1ps
module lane_overrange_output_config #(
  parameter int SAMPLE_W = 12
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Settings owned elsewhere.
  input wire logic i_link_enable,
  input wire logic [7:0] i_link_mode_lanes,
  input wire logic i_link_mode_is_64b66b,
  input wire logic [3:0] i_link_test_pattern_select,
  input wire logic i_channel_power_down,
  // Down-converter samples, signed.
  input wire logic i_sample_valid,
  input wire logic [SAMPLE_W-1:0] i_sample_i,
  input wire logic [SAMPLE_W-1:0] i_sample_q,
  // Lane controls.
  output logic [7:0] o_lane_clk_en,
  output logic [7:0] o_lane_ser_en,
  output logic [7:0] o_lane_ramp,
  output logic [3:0] o_lane_pattern,
  // Sync word controls.
  output logic o_sync_crc12,
  output logic o_sync_fec,
  output logic [1:0] o_sync_cmd,
  // Filter gain.
  output logic o_filter_gain_double,
  // Tagged samples.
  output logic o_tag_valid,
  output logic [SAMPLE_W-1:0] o_tag_i,
  output logic [SAMPLE_W-1:0] o_tag_q,
  output logic o_ctrl_bit0,
  output logic o_ctrl_bit1,
  // Over-range pins.
  output logic o_overrange_pin_a0,
  output logic o_overrange_pin_a1
);
  logic [7:0] spare_q;
  logic [7:0] sync_q;
  logic [7:0] gain_q;
  logic [7:0] thr_i_q;
  logic [7:0] thr_q_q;
  logic [7:0] ovr_q;
  logic [11:0] idx;
  logic wr_en;
  logic [7:0] rd_d;
  logic hit_i;
  logic hit_q;
  logic [7:0] mag_i;
  logic [7:0] mag_q;
  logic [7:0] spare_only;
  logic [7:0] lane_clk;
  logic ramp_pat;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus.

  // Word index; the low address bits are ignored so every register is one word.
  assign idx = i_paddr[lane_ovr_pkg::ADDR_SHIFT +: 12];
  assign wr_en = i_psel && i_penable && i_pwrite;
  // Zero wait states: the access phase always finishes in one cycle.
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  // Each register stores all eight bits so reserved bits read back.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      spare_q <= lane_ovr_pkg::RST_SPARE_LANE;
      sync_q <= lane_ovr_pkg::RST_SYNC_MODE;
      gain_q <= lane_ovr_pkg::RST_GAIN_CFG;
      thr_i_q <= lane_ovr_pkg::RST_THR_I;
      thr_q_q <= lane_ovr_pkg::RST_THR_Q;
      ovr_q <= lane_ovr_pkg::RST_OVERRANGE_OUTPUT_CONFIG;
    end else if (wr_en) begin
      unique case (idx)
        lane_ovr_pkg::IDX_SPARE_LANE: spare_q <= i_pwdata[7:0];
        lane_ovr_pkg::IDX_SYNC_MODE: sync_q <= i_pwdata[7:0];
        lane_ovr_pkg::IDX_GAIN_CFG: gain_q <= i_pwdata[7:0];
        lane_ovr_pkg::IDX_THR_I: thr_i_q <= i_pwdata[7:0];
        lane_ovr_pkg::IDX_THR_Q: thr_q_q <= i_pwdata[7:0];
        lane_ovr_pkg::IDX_OVERRANGE_OUTPUT_CONFIG: ovr_q <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped words read zero.
  always_comb begin
    unique case (idx)
      lane_ovr_pkg::IDX_SPARE_LANE: rd_d = spare_q;
      lane_ovr_pkg::IDX_SYNC_MODE: rd_d = sync_q;
      lane_ovr_pkg::IDX_GAIN_CFG: rd_d = gain_q;
      lane_ovr_pkg::IDX_THR_I: rd_d = thr_i_q;
      lane_ovr_pkg::IDX_THR_Q: rd_d = thr_q_q;
      lane_ovr_pkg::IDX_OVERRANGE_OUTPUT_CONFIG: rd_d = ovr_q;
      default: rd_d = 8'h00;
    endcase
  end

  assign o_prdata = {24'h000000, rd_d};

  //////////////////////////////////////////////////////////////////////////////
  // Spare lane enables.

  // Lane 0 is never spare; register bit n maps to lane n.
  assign spare_only = {spare_q[lane_ovr_pkg::SPARE_LANE_MSB:lane_ovr_pkg::SPARE_LANE_LSB], 1'b0}
                      & ~i_link_mode_lanes;
  // Power-down wins over every spare enable.
  assign lane_clk = i_channel_power_down ? 8'h00
                  : (i_link_mode_lanes
                     | {spare_q[lane_ovr_pkg::SPARE_LANE_MSB:lane_ovr_pkg::SPARE_LANE_LSB],
                        1'b0});
  assign ramp_pat = (i_link_test_pattern_select == lane_ovr_pkg::TP_NONE)
                 || (i_link_test_pattern_select == lane_ovr_pkg::TP_ALT);

  // Lane outputs registered. A serializer only gets a clock if every lower lane
  // is clocked, so a gap in the lane set silences every serializer above it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_lane_clk_en <= 8'h00;
      o_lane_ser_en <= 8'h00;
      o_lane_ramp <= 8'h00;
      o_lane_pattern <= lane_ovr_pkg::TP_NONE;
    end else begin
      o_lane_clk_en <= lane_clk;
      for (int n = 0; n < lane_ovr_pkg::LANES; n++) begin
        o_lane_ser_en[n] <= lane_clk[n]
                            && ((n == 0) || (&(lane_clk | ~((8'h01 << n) - 8'h01))))
                            && (i_link_mode_lanes[n]
                                || spare_q[lane_ovr_pkg::SPARE_SER_BIT]);
        o_lane_ramp[n] <= spare_only[n] && !i_channel_power_down && ramp_pat;
      end
      o_lane_pattern <= i_link_test_pattern_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync word and filter gain.

  // Reserved modes send neither stream; outside 64b/66b the field is ignored.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sync_crc12 <= 1'b0;
      o_sync_fec <= 1'b0;
      o_filter_gain_double <= 1'b0;
    end else begin
      o_sync_crc12 <= i_link_mode_is_64b66b && (sync_q[1:0] == lane_ovr_pkg::SH_CRC12);
      o_sync_fec <= i_link_mode_is_64b66b && (sync_q[1:0] == lane_ovr_pkg::SH_FEC);
      o_filter_gain_double <= gain_q[lane_ovr_pkg::FILTER_GAIN_DOUBLE_BIT];
    end
  end

  assign o_sync_cmd = 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Over-range detection.

  // Magnitude of a two's complement sample, top eight bits; threshold/256 of
  // full scale. The most negative code saturates rather than wrapping.
  function automatic logic [7:0] mag8(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    a = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
    if (s[SAMPLE_W-1] && a[SAMPLE_W-1]) begin
      mag8 = 8'hFF;
    end else begin
      mag8 = {a[SAMPLE_W-2 -: 7], 1'b0} | 8'(a[SAMPLE_W-9]);
    end
  endfunction

  assign mag_i = mag8(i_sample_i);
  assign mag_q = mag8(i_sample_q);
  assign hit_i = i_sample_valid && (mag_i >= thr_i_q);
  assign hit_q = i_sample_valid && (mag_q >= thr_q_q);

  // Samples and their control bits leave together one cycle later.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tag_valid <= 1'b0;
      o_tag_i <= '0;
      o_tag_q <= '0;
      o_ctrl_bit0 <= 1'b0;
      o_ctrl_bit1 <= 1'b0;
    end else begin
      o_tag_valid <= i_sample_valid;
      o_tag_i <= i_sample_i;
      o_tag_q <= i_sample_q;
      o_ctrl_bit0 <= hit_i;
      o_ctrl_bit1 <= hit_q;
    end
  end

  // One stretcher per pin; stream tags above are not gated by the pin enable.
  ovr_stretch u_pin_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(ovr_q[lane_ovr_pkg::PIN_EN_BIT]),
    .i_exp(ovr_q[lane_ovr_pkg::HOLD_EXP_MSB:0]),
    .i_hit(hit_i),
    .o_pin(o_overrange_pin_a0)
  );

  ovr_stretch u_pin_q (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(ovr_q[lane_ovr_pkg::PIN_EN_BIT]),
    .i_exp(ovr_q[lane_ovr_pkg::HOLD_EXP_MSB:0]),
    .i_hit(hit_q),
    .o_pin(o_overrange_pin_a1)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Reset cancels any window still in flight, so a pulse cut by reset is not
  // reported as too short.
  a_pins_gated: assert property (@(posedge i_clk) disable iff (i_rst)
    !ovr_q[lane_ovr_pkg::PIN_EN_BIT] |=> !o_overrange_pin_a0 && !o_overrange_pin_a1)
    else $error("over-range pin high while disabled");
  a_pulse_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    hit_i && ovr_q[3:0] == 4'h8 |=> o_overrange_pin_a0 [*8])
    else $error("over-range pulse too short");
  a_tag_i_hit: assert property (@(posedge i_clk) disable iff (i_rst)
    i_sample_valid && mag_i >= thr_i_q |=> o_ctrl_bit0)
    else $error("control bit 0 missing");
  a_tag_q_hit: assert property (@(posedge i_clk) disable iff (i_rst)
    i_sample_valid && mag_q >= thr_q_q |=> o_ctrl_bit1)
    else $error("control bit 1 missing");
  a_tag_q_miss: assert property (@(posedge i_clk) disable iff (i_rst)
    i_sample_valid && mag_q < thr_q_q |=> !o_ctrl_bit1)
    else $error("control bit 1 spurious");
  a_pd_lanes: assert property (@(posedge i_clk) disable iff (i_rst)
    i_channel_power_down |=> o_lane_clk_en == 8'h00 && o_lane_ser_en == 8'h00)
    else $error("lane active during power-down");
  a_spare_clock: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_channel_power_down && spare_q[lane_ovr_pkg::SPARE_LANE_LSB] |=> o_lane_clk_en[1])
    else $error("spare lane clock missing");
  a_ser_clocks: assert property (@(posedge i_clk) disable iff (i_rst)
    !spare_q[lane_ovr_pkg::SPARE_SER_BIT] && !i_channel_power_down
    |=> (o_lane_ser_en & ~$past(i_link_mode_lanes)) == 8'h00)
    else $error("spare serializer on without enable");
  a_ser_chain: assert property (@(posedge i_clk) disable iff (i_rst)
    o_lane_ser_en[2] |-> o_lane_clk_en[1] && o_lane_clk_en[0])
    else $error("serializer clocked with lower lane off");
  a_sync_mode: assert property (@(posedge i_clk) disable iff (i_rst)
    i_link_mode_is_64b66b && sync_q[1:0] == lane_ovr_pkg::SH_FEC
    |=> o_sync_fec && !o_sync_crc12)
    else $error("sync mode mismatch");
  a_sync_crc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_link_mode_is_64b66b && sync_q[1:0] == lane_ovr_pkg::SH_CRC12
    |=> o_sync_crc12 && !o_sync_fec)
    else $error("crc12 sync stream missing");
  a_sync_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_link_mode_is_64b66b |=> !o_sync_crc12 && !o_sync_fec)
    else $error("sync stream outside 64b/66b mode");
  a_cmd_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    o_sync_cmd == 2'h0)
    else $error("command field not idle");
  a_gain_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    gain_q[lane_ovr_pkg::FILTER_GAIN_DOUBLE_BIT] |=> o_filter_gain_double)
    else $error("filter gain filter_gain_double missing");
  a_ramp_case: assert property (@(posedge i_clk) disable iff (i_rst)
    o_lane_ramp != 8'h00 |-> $past(ramp_pat))
    else $error("ramp with wrong pattern");
  a_prdata_upper: assert property (@(posedge i_clk) disable iff (i_rst)
    i_psel |-> o_prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  c_pin_pulse: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_overrange_pin_a0));
  c_spare_ser: cover property (@(posedge i_clk) disable iff (i_rst) o_lane_ser_en[7]);
  c_ramp: cover property (@(posedge i_clk) disable iff (i_rst) o_lane_ramp != 8'h00);
  c_fec: cover property (@(posedge i_clk) disable iff (i_rst) o_sync_fec);
  c_crc12: cover property (@(posedge i_clk) disable iff (i_rst) o_sync_crc12);
endmodule

/* dv/lane_rx_model.sv */
// Receiver-side model that watches the lane and sync word controls for states it cannot lock to.
`timescale 1ns/1ps
module lane_rx_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Lane and sync word view.
  input wire logic [7:0] i_clk_en,
  input wire logic [7:0] i_ser_en,
  input wire logic i_crc12,
  input wire logic i_fec,
  input wire logic [1:0] i_cmd,
  // Fault count.
  output int o_faults
);
  initial o_faults = 0;
  // A serializer without a lane clock sends nothing, and mixed sync streams never lock.
  always @(posedge i_clk) begin
    if (!i_rst) begin
      if ((i_ser_en & ~i_clk_en) !== 8'h00) o_faults++;
      if ((i_crc12 & i_fec) !== 1'b0) o_faults++;
      if (i_cmd !== 2'h0) o_faults++;
    end
  end
endmodule

/* dv/tb.sv */
// Self-checking bench for the lane, sync word, gain and over-range block.
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, le = 0, is64 = 0, pd = 0;
  logic sv = 0, sync_crc, sync_fec, gain, tv, c0, c1, pa0, pa1;
  logic [15:0] paddr = 16'h0000, lf = 16'hF18D;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] lm = 8'h00, cken, seren, ramp, thr_i, thr_q;
  logic [3:0] pat = 4'h0, lpat;
  logic [1:0] cmd;
  logic [11:0] s_i = 12'h000, s_q = 12'h000, t_i, t_q;
  logic [11:0] idx [6] = '{lane_ovr_pkg::IDX_SPARE_LANE, lane_ovr_pkg::IDX_SYNC_MODE,
    lane_ovr_pkg::IDX_GAIN_CFG, lane_ovr_pkg::IDX_THR_I, lane_ovr_pkg::IDX_THR_Q,
    lane_ovr_pkg::IDX_OVERRANGE_OUTPUT_CONFIG};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'hF2, 8'hAB, 8'h07};
  logic [3:0] pats [4] = '{4'h0, 4'h4, 4'h5, 4'h3};
  logic [31:0] rd_q [$];
  logic [25:0] tag_q [$];
  int fail_count = 0, cmp_count = 0, faults, na, nb;
  ////////////////////////////////////////////////////////////////////////////////
  // A 100 ns clock.
  always #50 clk = ~clk;
  lane_overrange_output_config #(.SAMPLE_W(12)) i_dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_link_enable(le), .i_link_mode_lanes(lm), .i_link_mode_is_64b66b(is64),
    .i_link_test_pattern_select(pat), .i_channel_power_down(pd), .i_sample_valid(sv),
    .i_sample_i(s_i), .i_sample_q(s_q), .o_lane_clk_en(cken), .o_lane_ser_en(seren),
    .o_lane_ramp(ramp), .o_lane_pattern(lpat), .o_sync_crc12(sync_crc), .o_sync_fec(sync_fec),
    .o_sync_cmd(cmd), .o_filter_gain_double(gain), .o_tag_valid(tv), .o_tag_i(t_i),
    .o_tag_q(t_q), .o_ctrl_bit0(c0), .o_ctrl_bit1(c1), .o_overrange_pin_a0(pa0),
    .o_overrange_pin_a1(pa1));
  lane_rx_model i_rx (.i_clk(clk), .i_rst(rst), .i_clk_en(cken), .i_ser_en(seren),
    .i_crc12(sync_crc), .i_fec(sync_fec), .i_cmd(cmd), .o_faults(faults));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  // The most negative sample has no positive twin, so it saturates.
  function automatic logic [7:0] mag(input logic [11:0] s);
    logic [11:0] a;
    a = s[11] ? -s : s;
    return (s == 12'h800) ? 8'hFF : a[10:3];
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; the request stands until pready is seen at an edge.
  // Only the watchdog ends a wait for pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    if (!w) rd_q.push_back({24'h0, e});
    psel <= 1;
    pwr <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= {16'(rnd()), 8'(rnd()), d};
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic smp(input logic [11:0] si, input logic [11:0] sq);
    tag_q.push_back({si, sq, mag(sq) >= thr_q, mag(si) >= thr_i});
    sv <= 1;
    s_i <= si;
    s_q <= sq;
    @(posedge clk);
  endtask
  task automatic lanes(input logic [7:0] m, input logic [7:0] sp, input logic [3:0] p,
                       input logic d);
    logic [7:0] c, s, r, lo;
    le <= 0;
    apb(1, idx[0], sp, 8'h00);
    le <= 1;
    lm <= m;
    pat <= p;
    pd <= d;
    repeat (2) @(posedge clk);
    c = d ? 8'h00 : (m | {sp[7:1], 1'b0});
    for (int n = 0; n < 8; n++) begin
      lo = (8'h01 << n) - 8'h01;
      s[n] = c[n] && ((c & lo) == lo) && (m[n] || sp[0]);
      r[n] = c[n] && !m[n] && (p == 4'h0 || p == 4'h5);
    end
    cmp("clk_en", c, cken);
    cmp("ser_en", s, seren);
    cmp("ramp", r, ramp);
    cmp("pattern", p, lpat);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Results are matched against the oldest note as they appear.
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr) cmp("prdata", rd_q.pop_front(), prdata);
    if (psel && pen && pready === 1'b1) cmp("pslverr", 32'h0, {31'h0, pslverr});
    if (tv === 1'b1) cmp("tagged_sample", tag_q.pop_front(), {t_i, t_q, c1, c0});
  end
  // Watchdog, sized well above the roughly 700 cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [7:0] d;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int k = 0; k < 6; k++) apb(0, idx[k], 8'h00, rv[k]);
    apb(1, 12'h300, 8'h5A, 8'h00);
    apb(0, 12'h300, 8'h00, 8'h00);
    for (int k = 0; k < 6; k++) begin
      d = 8'(rnd());
      apb(1, idx[k], d, 8'h00);
      apb(0, idx[k], 8'h00, d);
    end
    $display("test registers done");
    lanes(8'h00, 8'hFD, 4'h0, 0);
    lanes(8'h01, 8'hFF, 4'h5, 0);
    lanes(8'h01, 8'hFF, 4'h4, 1);
    for (int k = 0; k < 12; k++) lanes(8'(rnd()), 8'(rnd()), pats[k % 4], k % 5 == 4);
    $display("test lanes done");
    le <= 0;
    for (int k = 0; k < 8; k++) begin
      is64 <= k[0];
      apb(1, idx[1], {6'(rnd()), k[2:1]}, 8'h00);
      repeat (2) @(posedge clk);
      cmp("crc12", k[0] && k[2:1] == 2'h0, sync_crc);
      cmp("fec", k[0] && k[2:1] == 2'h2, sync_fec);
      cmp("cmd", 2'h0, cmd);
      apb(1, idx[2], {7'(rnd()), k[0]}, 8'h00);
      repeat (2) @(posedge clk);
      cmp("gain", k[0], gain);
    end
    $display("test sync_gain done");
    // Pins stay disabled here, so no stretch from these samples leaks into the pin test.
    apb(1, idx[5], 8'h00, 8'h00);
    thr_i = 8'(rnd());
    thr_q = 8'(rnd());
    apb(1, idx[3], thr_i, 8'h00);
    apb(1, idx[4], thr_q, 8'h00);
    smp({1'b0, thr_i, 3'h0}, {1'b0, thr_q, 3'h0} - 12'h008);
    smp(-{1'b0, thr_i, 3'h7}, 12'h800);
    for (int k = 0; k < 16; k++) smp(12'(rnd()), 12'(rnd()));
    sv <= 0;
    repeat (2) @(posedge clk);
    $display("test thresholds done");
    for (int e = 0; e < 4; e++) begin
      apb(1, idx[5], e < 3 ? {5'h01, e[2:0]} : 8'h07, 8'h00);
      smp(12'h7FF, 12'h801);
      sv <= 0;
      na = 0;
      nb = 0;
      repeat (100) begin
        @(posedge clk);
        na += (pa0 === 1'b1);
        nb += (pa1 === 1'b1);
      end
      cmp("pin_a0_cycles", e < 3 ? 8 << e : 0, na);
      cmp("pin_a1_cycles", e < 3 ? 8 << e : 0, nb);
    end
    $display("test pins done");
    // A second reset mid-run must bring every register back to its default.
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int k = 0; k < 6; k++) apb(0, idx[k], 8'h00, rv[k]);
    $display("test reset done");
    cmp("pending", 32'h0, 32'(rd_q.size() + tag_q.size()));
    cmp("rx_faults", 0, faults);
    conclude();
  end
endmodule
